// >>> bench/irc_bus_peer.sv
// another master on the two-wire bus: start, address byte, ack sample, stop
// assumes: lines are wired-and with pull-ups; release means 1
`timescale 1ns/1ps
`default_nettype none
module irc_bus_peer
(
    input  wire logic clk,
    input  wire logic sdaLine,
    output logic      sclRel,
    output logic      sdaRel
);
    localparam int QTR = 10; // quarter bit in clk cycles

    initial
    begin
        sclRel = 1'b1;
        sdaRel = 1'b1;
    end

    // wait a quarter bit, then set both lines
    task automatic step(input logic scl, input logic sda);
    begin
        repeat (QTR) @(negedge clk);
        sclRel = scl;
        sdaRel = sda;
    end
    endtask

    // one address byte, msb first; ack is the sda level at the ninth rise
    task automatic send_addr(input logic [7:0] b, output logic ack);
        int i;
    begin
        step(1'b1, 1'b0); // start
        for (i = 7; i >= 0; i--)
        begin
            step(1'b0, sdaRel);
            step(1'b0, b[i]);
            step(1'b1, b[i]);
            step(1'b1, b[i]);
        end
        step(1'b0, b[0]);
        step(1'b0, 1'b1); // let the slave answer
        step(1'b1, 1'b1);
        ack = sdaLine;
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1); // stop
    end
    endtask
endmodule
`default_nettype wire

// >>> bench/irc_rate_addr_assertions.sv
// checker for the rate/address block: register, stop and match relations
// assumes: bound to irc_rate_addr, one clk domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module irc_rate_addr_assertions
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       regIndex,
    input wire logic       regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       moduleEnable,
    input wire logic       stopShallow,
    input wire logic       stopDeepEntry,
    input wire logic       sclOut,
    input wire logic       sclOe,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       addrMatch,
    input wire logic       slaveRw,
    input wire logic       wakeRequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // an address write that is taken, followed by a plain cycle on the address index
    sequence addr_write_s;
        regWrite && !regIndex && !stopShallow && !stopDeepEntry ##1 !regIndex && !stopShallow && !stopDeepEntry;
    endsequence

    a_lines_low_only: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
        else $error("bus line driven high");
    a_disable_release: assert property (!moduleEnable && !stopShallow |=> sclOe && sdaOe)
        else $error("line held while disabled");
    a_addr_readback: assert property (addr_write_s |=> regRdata == {$past(regWdata[7:1], 2), 1'b0})
        else $error("own address readback wrong");
    a_rate_readback: assert property ($past(regWrite && regIndex && !stopShallow && !stopDeepEntry, 2)
        && $past(regIndex && !stopShallow && !stopDeepEntry) |-> regRdata == $past(regWdata, 2))
        else $error("rate select readback wrong");
    a_shallow_freeze: assert property (stopShallow && !stopDeepEntry |=> $stable(regRdata) && $stable(sclOe)
        && $stable(sdaOe) && $stable(addrMatch))
        else $error("state moved in shallow stop");
    a_deep_clears: assert property (stopDeepEntry |=> regRdata == 8'h00 && sclOe && sdaOe && !addrMatch && !slaveRw)
        else $error("deep stop left state");
    a_wake_pairs: assert property (wakeRequest == addrMatch)
        else $error("wake request not paired with match");
    a_match_single: assert property (addrMatch && !stopShallow |=> !addrMatch)
        else $error("match pulse too long");
    a_rw_on_match: assert property ($changed(slaveRw) |-> addrMatch || $past(addrMatch) || $past(stopDeepEntry))
        else $error("direction bit moved without match");

    c_match: cover property (addrMatch);
    c_deep: cover property (stopDeepEntry);
    c_scl_fall: cover property ($fell(sclOe));
endmodule

bind irc_rate_addr irc_rate_addr_assertions i_chk
(
    .clk(clk), .resetn(resetn), .regIndex(regIndex), .regWrite(regWrite), .regWdata(regWdata),
    .regRdata(regRdata), .moduleEnable(moduleEnable), .stopShallow(stopShallow),
    .stopDeepEntry(stopDeepEntry), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrMatch(addrMatch), .slaveRw(slaveRw), .wakeRequest(wakeRequest)
);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the rate/address block
// assumes: checker bound by its own file; peer model drives the far side
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk;
    logic       resetn;
    logic       regIndex;
    logic       regWrite;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       moduleEnable;
    logic       sclRun;
    logic       sdaTxEnable;
    logic       sdaTxBit;
    logic       waitMode;
    logic       stopShallow;
    logic       stopDeepEntry;
    logic       sclOut;
    logic       sclOe;
    logic       sdaOut;
    logic       sdaOe;
    logic       addrMatch;
    logic       slaveRw;
    logic       wakeRequest;
    logic       sclRel;
    logic       sdaRel;
    logic       ack;
    int         mismatches;
    int         check_count;
    int         matchSeen;
    int         d0;
    int         d1;
    int         d2;
    wire logic  sclLine;
    wire logic  sdaLine;

    // wired-and of the open-drain lines with pull-ups
    assign sclLine = (sclOe ? 1'b1 : sclOut) & sclRel;
    assign sdaLine = (sdaOe ? 1'b1 : sdaOut) & sdaRel;

    irc_rate_addr i_dut
    (
        .clk(clk), .resetn(resetn), .regIndex(regIndex), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .moduleEnable(moduleEnable), .sclRun(sclRun), .sdaTxEnable(sdaTxEnable),
        .sdaTxBit(sdaTxBit), .waitMode(waitMode), .stopShallow(stopShallow), .stopDeepEntry(stopDeepEntry),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrMatch(addrMatch), .slaveRw(slaveRw), .wakeRequest(wakeRequest)
    );
    irc_bus_peer i_peer
    (
        .clk(clk), .sdaLine(sdaLine), .sclRel(sclRel), .sdaRel(sdaRel)
    );

    // clock and wake pulse count
    always #50 clk = ~clk;
    always @(negedge clk)
        if (wakeRequest === 1'b1) matchSeen++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    end
    endtask

    task automatic conclude();
    begin
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    task automatic write_reg(input logic i, input logic [7:0] d);
    begin
        @(negedge clk);
        regIndex = i;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    end
    endtask

    task automatic read_check(input logic i, input logic [7:0] exp);
    begin
        @(negedge clk);
        regIndex = i;
        repeat (2) @(negedge clk);
        check(regRdata, exp);
    end
    endtask

    // count cycles until the scl enable shows lvl
    task automatic wait_scl(input logic lvl, output int n);
    begin
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (sclOe !== lvl && n < 9000);
    end
    endtask

    task automatic scl_period(input logic [7:0] rate, input int p);
        int n;
        int lo;
    begin
        write_reg(1'b1, rate);
        sclRun = 1'b1;
        wait_scl(1'b1, n);
        wait_scl(1'b0, n);
        wait_scl(1'b1, lo);
        wait_scl(1'b0, n);
        check(lo, p / 2);
        check(lo + n, p);
        sclRun = 1'b0;
    end
    endtask

    // cycles from a seen scl fall until sda is pulled
    task automatic hold_delay(input logic [7:0] rate, output int d);
        int n;
    begin
        write_reg(1'b1, rate);
        sdaTxEnable = 1'b1;
        sdaTxBit = 1'b1;
        sclRun = 1'b1;
        wait_scl(1'b1, n);
        wait_scl(1'b0, n);
        sdaTxBit = 1'b0;
        d = 0;
        while (sdaOe !== 1'b0 && d < 2000)
        begin
            @(negedge clk);
            d++;
        end
        sclRun = 1'b0;
        sdaTxEnable = 1'b0;
        moduleEnable = 1'b0;
        @(negedge clk);
        moduleEnable = 1'b1;
    end
    endtask

    // watchdog
    initial
    begin
        #6000000;
        mismatches++;
        conclude();
    end

    // main sequence
    initial
    begin
        {clk, resetn, regIndex, regWrite, regWdata, sclRun, sdaTxEnable, sdaTxBit} = '0;
        {waitMode, stopShallow, stopDeepEntry} = '0;
        moduleEnable = 1'b1;
        mismatches = 0;
        check_count = 0;
        matchSeen = 0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        read_check(1'b0, 8'h00);
        read_check(1'b1, 8'h00);
        check(sclOe & sdaOe, 1'b1);
        scl_period(8'h00, 20);
        scl_period(8'h41, 44);
        scl_period(8'h87, 160);
        scl_period(8'hC5, 30);
        scl_period(8'h3F, 3840);
        scl_period(8'h22, 224);
        hold_delay(8'h40, d0);
        hold_delay(8'h80, d1);
        hold_delay(8'h82, d2);
        check(d0 >= 7, 1'b1);
        check(d1, d0);
        check(d2, d1 + 1);
        write_reg(1'b0, 8'h5A);
        write_reg(1'b1, 8'h00);
        waitMode = 1'b1;
        i_peer.send_addr(8'h5B, ack);
        check(ack, 1'b0);
        check(matchSeen, 1);
        check(slaveRw, 1'b1);
        i_peer.send_addr(8'h34, ack);
        check(ack, 1'b1);
        check(matchSeen, 1);
        stopShallow = 1'b1;
        write_reg(1'b1, 8'h55);
        stopShallow = 1'b0;
        read_check(1'b1, 8'h00);
        write_reg(1'b0, 8'hA5);
        read_check(1'b0, 8'hA4);
        write_reg(1'b1, 8'h4B);
        stopDeepEntry = 1'b1;
        @(negedge clk);
        stopDeepEntry = 1'b0;
        read_check(1'b0, 8'h00);
        read_check(1'b1, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire

// >>> hw/irc_pin_sync.sv
// three-flop synchroniser for an open-drain bus line
// assumes: pin level is asynchronous to clk; idle line is high
`timescale 1ns/1ps
`default_nettype none
`include "irc_regs.svh"
module irc_pin_sync
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pinIn,
    output logic      level
);
    irc_pkg::irc_sync_t st;
    irc_pkg::irc_sync_t next_st;

    // level changes only when stages two and three agree
    always_comb
    begin
        next_st = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3)
        begin
            next_st.level = st.s3;
        end
    end

    // state register, lines idle high
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= {4{`IRC_PIN_IDLE}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule
`default_nettype wire

// >>> hw/irc_pkg.sv
// types shared by the rate/address block modules
// assumes: nothing beyond a SystemVerilog compiler
package irc_pkg;

    // bus observation phase of the slave address detector
    typedef enum logic [1:0] {
        IRC_IDLE = 2'b00,
        IRC_ADDR = 2'b01,
        IRC_ACK  = 2'b10,
        IRC_DATA = 2'b11
    } irc_phase_t;

    // three-stage pin synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } irc_sync_t;

    // whole state of the top module
    typedef struct packed {
        logic [6:0]  ownAddr;
        logic [7:0]  rateSel;
        logic [7:0]  regRdata;
        logic [13:0] periodCnt;
        logic        sclLow;
        logic        sdaLow;
        logic [9:0]  holdCnt;
        logic        holdBusy;
        logic        ackPending;
        irc_phase_t  phase;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic        addrMatch;
        logic        slaveRw;
        logic        wakeRequest;
        logic        prevScl;
        logic        prevSda;
    } irc_state_t;

endpackage

// >>> hw/irc_rate_addr.sv
// rate/address front end of the two-wire serial module
// assumes: control engine and power manager on the same clk; bus pins open drain
`timescale 1ns/1ps
`default_nettype none
`include "irc_regs.svh"
// Functional notes
// (R01) scl and sda only pulled low or released; pins shared with port bits
// (R02) identical behaviour in normal and monitor modes
// (R03) keeps running in wait mode and can request a wake-up
// (R04) shallow stop: inactive, all register contents kept
// (R05) deepest stop entry returns every register to reset values
// (R06) own address from upper seven bits; answer when that address is called
// (R07) multiplier code 00,01,10 gives factor 1,2,4; 11 reserved
// (R08) six-bit rate index selects divider and hold through one lookup
// (R09) one scl period every factor times divider clock cycles
// (R10) after each scl falling edge wait the hold interval before changing sda
// (R11) hold lasts hold-value clock cycles, not scaled by the factor
// (R12) lookup follows the 64-entry divider and hold table
// (R13) software must not write code 11; treated as factor 1
module irc_rate_addr
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       regIndex,
    input  wire logic       regWrite,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic       moduleEnable,
    input  wire logic       sclRun,
    input  wire logic       sdaTxEnable,
    input  wire logic       sdaTxBit,
    input  wire logic       waitMode,
    input  wire logic       stopShallow,
    input  wire logic       stopDeepEntry,
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOe,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    output logic            addrMatch,
    output logic            slaveRw,
    output logic            wakeRequest
);
    irc_pkg::irc_state_t st;
    irc_pkg::irc_state_t next_st;
    logic                sclLevel;
    logic                sdaLevel;
    logic [13:0]         period;
    logic [13:0]         half;
    logic                sclFall;
    logic                sclRise;
    logic                startSeen;
    logic                stopSeen;

    irc_rate_if rateBus();

    // bus lines through three-flop synchronisers
    irc_pin_sync sclSync
    (
        .clk    (clk),
        .resetn (resetn),
        .pinIn  (sclIn),
        .level  (sclLevel)
    );
    irc_pin_sync sdaSync
    (
        .clk    (clk),
        .resetn (resetn),
        .pinIn  (sdaIn),
        .level  (sdaLevel)
    );

    // divider and hold from the rate index
    irc_rate_lookup rateTable
    (
        .rate (rateBus.lookup)
    );
    assign rateBus.rateIndex = st.rateSel[`IRC_ICR_MSB:`IRC_ICR_LSB]; // R08

    // scl period in clock cycles: factor times divider
    function automatic logic [13:0] ircPeriod(input logic [1:0] rate_multiplier_code, input logic [11:0] div);
        logic [13:0] p;
        case (rate_multiplier_code)
            `IRC_RATE_MULTIPLIER_CODE_X1: p = {2'b00, div}; // R07
            `IRC_RATE_MULTIPLIER_CODE_X2: p = {1'b0, div, 1'b0}; // R07
            `IRC_RATE_MULTIPLIER_CODE_X4: p = {div, 2'b00}; // R07
            default:      p = {2'b00, div}; // R13
        endcase
        return p;
    endfunction

    assign period = ircPeriod(st.rateSel[`IRC_RATE_MULTIPLIER_CODE_MSB:`IRC_RATE_MULTIPLIER_CODE_LSB], rateBus.sclDivider); // R09
    assign half = {1'b0, period[13:1]};

    // bus events seen on the synchronised lines
    assign sclFall = st.prevScl & ~sclLevel;
    assign sclRise = ~st.prevScl & sclLevel;
    assign startSeen = sclLevel & st.prevScl & st.prevSda & ~sdaLevel;
    assign stopSeen = sclLevel & st.prevScl & ~st.prevSda & sdaLevel;

    // next state; wait and monitor modes change nothing here
    always_comb
    begin
        next_st = st; // R02
        next_st.addrMatch = 1'b0;
        next_st.wakeRequest = 1'b0;
        next_st.prevScl = sclLevel;
        next_st.prevSda = sdaLevel;

        // register writes and read data
        if (regWrite)
        begin
            if (regIndex == `IRC_IDX_ADDR)
            begin
                next_st.ownAddr = regWdata[`IRC_ADDR_MSB:`IRC_ADDR_LSB]; // R06
            end
            else
            begin
                next_st.rateSel = regWdata; // R07
            end
        end
        if (regIndex == `IRC_IDX_ADDR)
        begin
            next_st.regRdata = {st.ownAddr, 1'b0};
        end
        else
        begin
            next_st.regRdata = st.rateSel;
        end

        // scl generation: low for first half, released for the rest
        if (moduleEnable && sclRun)
        begin
            if (st.periodCnt >= 14'(period - 14'h0001))
            begin
                next_st.periodCnt = 14'h0000; // R09
            end
            else
            begin
                next_st.periodCnt = 14'(st.periodCnt + 14'h0001);
            end
            next_st.sclLow = (next_st.periodCnt < half); // R01
        end
        else
        begin
            next_st.periodCnt = 14'h0000;
            next_st.sclLow = 1'b0; // R01
        end

        // sda changes only once the hold count has run out
        if (sclFall)
        begin
            next_st.holdBusy = 1'b1; // R10
            next_st.holdCnt = 10'h001;
        end
        else if (st.holdBusy)
        begin
            if (st.holdCnt >= rateBus.sdaHold)
            begin
                next_st.holdBusy = 1'b0; // R11
                next_st.sdaLow = st.ackPending | (sdaTxEnable & ~sdaTxBit); // R01
            end
            else
            begin
                next_st.holdCnt = 10'(st.holdCnt + 10'h001); // R11
            end
        end

        // address detection on the bus
        if (startSeen)
        begin
            next_st.phase = irc_pkg::IRC_ADDR;
            next_st.bitCnt = 4'h0;
            next_st.ackPending = 1'b0;
        end
        else if (stopSeen)
        begin
            next_st.phase = irc_pkg::IRC_IDLE;
            next_st.ackPending = 1'b0;
        end
        else if (sclRise)
        begin
            case (st.phase)
                irc_pkg::IRC_ADDR:
                begin
                    next_st.shift = {st.shift[6:0], sdaLevel};
                    next_st.bitCnt = 4'(st.bitCnt + 4'h1);
                    if (st.bitCnt == `IRC_LAST_BIT)
                    begin
                        if (st.shift[6:0] == st.ownAddr)
                        begin
                            next_st.phase = irc_pkg::IRC_ACK; // R06
                            next_st.ackPending = 1'b1; // R06
                            next_st.addrMatch = 1'b1; // R06
                            next_st.wakeRequest = 1'b1; // R03
                            next_st.slaveRw = sdaLevel;
                        end
                        else
                        begin
                            next_st.phase = irc_pkg::IRC_IDLE;
                        end
                    end
                end
                irc_pkg::IRC_ACK:
                begin
                    next_st.ackPending = 1'b0;
                    next_st.phase = irc_pkg::IRC_DATA;
                end
                irc_pkg::IRC_DATA:
                begin
                    next_st.phase = irc_pkg::IRC_DATA;
                end
                default:
                begin
                    next_st.phase = irc_pkg::IRC_IDLE;
                end
            endcase
        end

        // disabled module lets go of both lines
        if (!moduleEnable)
        begin
            next_st.phase = irc_pkg::IRC_IDLE;
            next_st.ackPending = 1'b0;
            next_st.holdBusy = 1'b0;
            next_st.sdaLow = 1'b0; // R01
            next_st.addrMatch = 1'b0;
            next_st.wakeRequest = 1'b0;
        end

        // shallow stop freezes everything, registers included
        if (stopShallow)
        begin
            next_st = st; // R04
        end

        // deepest stop entry restores reset contents
        if (stopDeepEntry)
        begin
            next_st = '0; // R05
            next_st.ownAddr = 7'(`IRC_ADDR_RST >> `IRC_ADDR_LSB); // R05
            next_st.rateSel = `IRC_RATE_RST; // R05
            next_st.prevScl = `IRC_PIN_IDLE;
            next_st.prevSda = `IRC_PIN_IDLE;
            next_st.phase = irc_pkg::IRC_IDLE;
        end
    end

    // single state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.ownAddr <= 7'(`IRC_ADDR_RST >> `IRC_ADDR_LSB);
            st.rateSel <= `IRC_RATE_RST;
            st.prevScl <= `IRC_PIN_IDLE;
            st.prevSda <= `IRC_PIN_IDLE;
            st.phase <= irc_pkg::IRC_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from state flops; enables low while pulling low
    assign regRdata = st.regRdata;
    assign sclOut = st.sclLow & ~st.sclLow; // R01
    assign sclOe = ~st.sclLow; // R01
    assign sdaOut = st.sdaLow & ~st.sdaLow; // R01
    assign sdaOe = ~st.sdaLow; // R01
    assign addrMatch = st.addrMatch;
    assign slaveRw = st.slaveRw;
    assign wakeRequest = st.wakeRequest; // R03

    // wait mode deliberately has no effect on the logic
    logic unusedWait;
    assign unusedWait = waitMode; // R03
endmodule
`default_nettype wire

// >>> hw/irc_rate_if.sv
// carrier between the top module and the rate index lookup
// assumes: one instance inside the top module
`timescale 1ns/1ps
`default_nettype none
interface irc_rate_if;
    logic [5:0]  rateIndex;
    logic [11:0] sclDivider;
    logic [9:0]  sdaHold;

    modport lookup
    (
        input  rateIndex,
        output sclDivider,
        output sdaHold
    );
    modport user
    (
        output rateIndex,
        input  sclDivider,
        input  sdaHold
    );
endinterface
`default_nettype wire

// >>> hw/irc_rate_lookup.sv
// 64-entry rate index lookup: scl divider and sda hold count
// assumes: purely combinational, driven through the rate interface
`timescale 1ns/1ps
`default_nettype none
module irc_rate_lookup
(
    irc_rate_if.lookup rate
);
    // base rows: codes 00..1F as {divider, hold}
    function automatic logic [21:0] ircBase(input logic [4:0] code);
        logic [21:0] r;
        r = {12'h014, 10'h007};
        case (code)
            5'h00: r = {12'h014, 10'h007};
            5'h01: r = {12'h016, 10'h007};
            5'h02: r = {12'h018, 10'h008};
            5'h03: r = {12'h01A, 10'h008};
            5'h04: r = {12'h01C, 10'h009};
            5'h05: r = {12'h01E, 10'h009};
            5'h06: r = {12'h022, 10'h00A};
            5'h07: r = {12'h028, 10'h00A};
            5'h08: r = {12'h01C, 10'h007};
            5'h09: r = {12'h020, 10'h007};
            5'h0A: r = {12'h024, 10'h009};
            5'h0B: r = {12'h028, 10'h009};
            5'h0C: r = {12'h02C, 10'h00B};
            5'h0D: r = {12'h030, 10'h00B};
            5'h0E: r = {12'h038, 10'h00D};
            5'h0F: r = {12'h044, 10'h00D};
            5'h10: r = {12'h030, 10'h009};
            5'h11: r = {12'h038, 10'h009};
            5'h12: r = {12'h040, 10'h00D};
            5'h13: r = {12'h048, 10'h00D};
            5'h14: r = {12'h050, 10'h011};
            5'h15: r = {12'h058, 10'h011};
            5'h16: r = {12'h068, 10'h015};
            5'h17: r = {12'h080, 10'h015};
            5'h18: r = {12'h050, 10'h009};
            5'h19: r = {12'h060, 10'h009};
            5'h1A: r = {12'h070, 10'h011};
            5'h1B: r = {12'h080, 10'h011};
            5'h1C: r = {12'h090, 10'h019};
            5'h1D: r = {12'h0A0, 10'h019};
            5'h1E: r = {12'h0C0, 10'h021};
            5'h1F: r = {12'h0F0, 10'h021};
            default: r = {12'h014, 10'h007};
        endcase
        return r;
    endfunction

    // codes 20..3F scale row 18..1F by 2,4,8,16; hold becomes k*(h-1)+1
    logic [21:0] base;
    logic [1:0]  scale;
    always_comb
    begin
        scale = rate.rateIndex[4:3];
        if (rate.rateIndex[5])
        begin
            base = ircBase({2'b11, rate.rateIndex[2:0]});
            // shift amount kept three bits wide so that scale 3 gives 16, not a wrap to 1
            rate.sclDivider = 12'(base[21:10] << ({1'b0, scale} + 3'h1)); // R12
            rate.sdaHold = 10'(((base[9:0] - 10'h001) << ({1'b0, scale} + 3'h1)) + 10'h001); // R12
        end
        else
        begin
            base = ircBase(rate.rateIndex[4:0]);
            rate.sclDivider = base[21:10]; // R12
            rate.sdaHold = base[9:0]; // R12
        end
    end
endmodule
`default_nettype wire

// >>> hw/irc_regs.svh
// register indices, field positions, reset values and fixed counts of the rate/address block
// assumes: included by bare name from files that need register layout
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH

`define IRC_IDX_ADDR   1'b0
`define IRC_IDX_RATE   1'b1
`define IRC_ADDR_RST   8'h00
`define IRC_RATE_RST   8'h00
`define IRC_ADDR_MSB   7
`define IRC_ADDR_LSB   1
`define IRC_RATE_MULTIPLIER_CODE_MSB   7
`define IRC_RATE_MULTIPLIER_CODE_LSB   6
`define IRC_ICR_MSB    5
`define IRC_ICR_LSB    0
`define IRC_RATE_MULTIPLIER_CODE_X1    2'b00
`define IRC_RATE_MULTIPLIER_CODE_X2    2'b01
`define IRC_RATE_MULTIPLIER_CODE_X4    2'b10
`define IRC_LAST_BIT   4'h7
`define IRC_PIN_IDLE   1'b1

`endif
